// [shared/ocs_pkg.sv]
// Package for the output capture and status register bank.
// Assumes one device clock and an Avalon-MM register slave with 32-bit words.
package ocs_pkg;
  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [3:0] IDX_STATUS = 4'h9;
  localparam logic [3:0] IDX_ONE_SHOT = 4'hA;
  localparam logic [3:0] IDX_CHECKSUM = 4'hB;
  localparam logic [3:0] IDX_I_LO = 4'hC;
  localparam logic [3:0] IDX_I_HI = 4'hD;
  localparam logic [3:0] IDX_Q_LO = 4'hE;
  localparam logic [3:0] IDX_Q_HI = 4'hF;
  // Interrupt block registers at indices of our own.
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h0;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] IDX_IRQ_CLEAR = 4'h2;
  // Status register bit positions.
  localparam int BIT_READY = 0;
  localparam int BIT_MISSED = 1;
  localparam int BIT_INT_EN = 2;
  localparam int BIT_SPARE = 3;
  localparam int BIT_PULSE_SEL = 4;
  localparam int BIT_OVF_GATE = 5;
  localparam int BIT_OVERFLOW = 6;
  localparam int BIT_POWER_DOWN = 7;
  // Interrupt event bit positions.
  localparam int EV_CAPTURE = 0;
  localparam int EV_MISSED = 1;
  localparam int EV_OVERFLOW = 2;
  localparam int EV_CHECKSUM = 3;
  localparam int EV_COUNT = 4;
  // Reset values.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CHECKSUM_RESET = 8'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // Power-down slow clock: 1 KHz tick from the 20 MHz device clock.
  localparam int CLK_HZ = 20000000;
  localparam int SLOW_HZ = 1000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  // Output sample carried as one bundle.
  typedef struct packed {
    logic [15:0] i_word;
    logic [15:0] q_word;
    logic block_strobe;
    logic frame_strobe;
  } ocs_sample_t;
endpackage

// [sim/ocs_host.sv]
// Processor model that owns the register bus of the status bank.
// Assumes waitrequest and read data settle before each rising edge of ref_clk.
`timescale 1ns/10ps
module ocs_host (
  input wire logic ref_clk, // Device clock.
  input wire logic avs_waitrequest, // Slave stall.
  input wire logic [31:0] avs_readdata, // Read data.
  output logic [5:0] avs_address, // Word index.
  output logic avs_read, // Read request.
  output logic avs_write, // Write request.
  output logic [31:0] avs_writedata, // Write data.
  output logic [3:0] avs_byteenable, // Byte enables.
  output logic timeout // High once a transfer never ended.
);
  // Idle bus from time zero, so no request floats during reset.
  initial begin
    avs_address = 6'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    timeout = 1'h0;
  end

  // One transfer, held until waitrequest is sampled low at a rising edge; read data is taken at that edge.
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    rd = 8'h00;
    @(posedge ref_clk);
    avs_address <= {2'h0, idx};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= 4'hF;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 40);
    rd = avs_readdata[7:0];
    if (avs_waitrequest !== 1'h0)
      timeout <= 1'h1;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the output capture and status bank.
// Assumes the host model drives the bus and this module drives the sample side.
`timescale 1ns/10ps
module testbench;
  localparam logic [3:0] ST = ocs_pkg::IDX_STATUS;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [5:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  ocs_pkg::ocs_sample_t sample_in = '0;
  logic sample_valid = 1'h0;
  logic overflow_evt = 1'h0;
  logic sync_n = 1'h1;
  logic int_n, ovf_pin_n, pulse_pin_n, slow_tick, power_down, irq, host_to;
  int err_count = 0;
  int total_checks = 0;
  int ovf_lows = 0;
  int os_lows = 0;
  int ticks = 0;
  logic [7:0] rv;

  always #25 ref_clk = !ref_clk;

  ocs_status i_ocs_status (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_in(sample_in),
    .sample_valid(sample_valid), .overflow_evt(overflow_evt), .sync_n(sync_n), .int_n(int_n),
    .ovf_pin_n(ovf_pin_n), .pulse_pin_n(pulse_pin_n), .slow_tick(slow_tick), .power_down(power_down), .irq(irq));
  ocs_host i_ocs_host (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .timeout(host_to));

  // Pin activity is counted mid-cycle, where registered pins have settled.
  always @(negedge ref_clk) begin
    ovf_lows += !ovf_pin_n;
    os_lows += !pulse_pin_n;
    ticks += slow_tick;
  end

  // A transfer that never finished ends the run at once.
  always @(posedge host_to) begin
    err_count++;
    complete_run();
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
    i_ocs_host.xfer(1'h0, idx, 8'h00, rv);
    chk($sformatf("register %0d", idx), rv, exp);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    i_ocs_host.xfer(1'h1, idx, d, rv);
  endtask

  // Pins are read mid-cycle so the launching edge has landed.
  task automatic pin(input string what, input int k, input logic e);
    logic v;
    @(negedge ref_clk);
    v = (k == 0) ? int_n : (k == 1) ? ovf_pin_n : (k == 2) ? irq : power_down;
    chk(what, {7'h00, v}, {7'h00, e});
  endtask

  // One-cycle event: 0 new sample, 1 overflow, 2 internal sync low.
  task automatic strobe(input int k, input logic [31:0] iq);
    @(posedge ref_clk);
    sample_in <= {iq, 2'h2};
    sample_valid <= (k == 0);
    overflow_evt <= (k == 1);
    sync_n <= (k != 2);
    @(posedge ref_clk);
    sample_valid <= 1'h0;
    overflow_evt <= 1'h0;
    sync_n <= 1'h1;
    repeat (3) @(negedge ref_clk);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    rdc(ST, ocs_pkg::STATUS_RESET);
    pin("int_n", 0, 1'h1);
    strobe(0, 32'h0);
    rdc(ST, 8'h02);
    wr(ST, 8'h03);
    rdc(ST, 8'h03);
    wr(ST, 8'h07);
    pin("int_n", 0, 1'h1);
    strobe(0, 32'h12345678);
    pin("int_n", 0, 1'h0);
    rdc(ST, 8'h06);
    rdc(ocs_pkg::IDX_I_LO, 8'h34);
    rdc(ocs_pkg::IDX_I_HI, 8'h12);
    rdc(ocs_pkg::IDX_Q_LO, 8'h78);
    rdc(ocs_pkg::IDX_Q_HI, 8'h56);
    wr(ST, 8'h01);
    rdc(ST, 8'h01);
    pin("int_n", 0, 1'h1);
    wr(ST, 8'h02);
    rdc(ST, 8'h00);
    // A sample lands at the very edge that accepts the request write.
    fork
      wr(ST, 8'h01);
      begin
        repeat (2) @(posedge ref_clk);
        sample_valid <= 1'h1;
        @(posedge ref_clk);
        sample_valid <= 1'h0;
      end
    join
    strobe(0, 32'h0);
    rdc(ST, 8'h03);
    rdc(ocs_pkg::IDX_I_HI, 8'h12);
    $display("test capture done");
    wr(ST, 8'h20);
    strobe(1, 32'h0);
    rdc(ST, 8'h60);
    pin("ovf_pin_n", 1, 1'h0);
    wr(ST, 8'h60);
    rdc(ST, 8'h60);
    wr(ST, 8'h20);
    rdc(ST, 8'h20);
    pin("ovf_pin_n", 1, 1'h1);
    wr(ST, 8'h10);
    ovf_lows = 0;
    strobe(1, 32'h0);
    rdc(ST, 8'h10);
    chk("ovf lows gated", ovf_lows[7:0], 8'h00);
    wr(ST, 8'h30);
    ovf_lows = 0;
    strobe(1, 32'h0);
    rdc(ST, 8'h70);
    chk("ovf lows pulse", ovf_lows[7:0], 8'h01);
    $display("test overflow done");
    wr(ST, 8'h00);
    os_lows = 0;
    wr(ocs_pkg::IDX_ONE_SHOT, 8'h00);
    wr(ocs_pkg::IDX_ONE_SHOT, 8'hA5);
    rdc(ocs_pkg::IDX_ONE_SHOT, 8'h00);
    chk("one-shot lows", os_lows[7:0], 8'h02);
    strobe(0, 32'hCAFE0001);
    strobe(2, 32'h0);
    strobe(2, 32'h0);
    rdc(ocs_pkg::IDX_CHECKSUM, 8'h00);
    $display("test one-shot and checksum done");
    wr(ST, 8'h80);
    ticks = 0;
    repeat (4) @(posedge ref_clk);
    chk("slow ticks", {7'h00, ticks < 2}, 8'h01);
    rdc(ST, 8'h80);
    pin("power_down", 3, 1'h1);
    wr(ST, 8'h00);
    @(posedge ref_clk);
    ticks = 0;
    repeat (4) @(posedge ref_clk);
    chk("run ticks", ticks[7:0], 8'h04);
    $display("test power-down done");
    rdc(ocs_pkg::IDX_IRQ_STATUS, 8'h0F);
    pin("irq", 2, 1'h0);
    wr(ocs_pkg::IDX_IRQ_ENABLE, 8'h04);
    pin("irq", 2, 1'h1);
    wr(ocs_pkg::IDX_IRQ_CLEAR, 8'h0F);
    rdc(ocs_pkg::IDX_IRQ_STATUS, 8'h00);
    pin("irq", 2, 1'h0);
    rdc(4'h5, 8'h00);
    $display("test interrupts done");
    complete_run();
  end
endmodule

// [src/ocs_status.sv]
// Output capture, status, one-shot and checksum register bank.
// Assumes sample_valid, overflow_evt and sync_n come from logic on ref_clk.
// Operation
// - Set capture request captures next sample, then hardware clears request.
// - New sample while request low sets missed flag.
// - Writing zero clears missed flag; writing one leaves it.
// - Interrupt pin high unless enabled; then it follows the request bit.
// - Pulse select low: overflow pin shows inverse of sticky overflow flag.
// - Pulse select and gate high: overflow pin pulses low one cycle.
// - Gate low: flag not set, pin not low; detection continues.
// - Gated overflow sets flag until software writes zero; one does nothing.
// - Power-down slows internal clock to about 1 KHz, settings kept.
// - Write 0x01 sets request, clears missed; 0x03 keeps missed.
// - Capture coinciding with request write leaves request high, no captures.
// - Any write to one-shot address pulses pin; nothing readable there.
// - Checksum is 8-bit non-linear feedback accumulation of strobes, I, Q.
// - Sync low latches checksum into register and clears generator.
// - Captured I and Q readable as low and high bytes at 12-15.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
module ocs_status (
  input wire logic ref_clk, // Device clock, 20 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [5:0] avs_address, // Word index.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte enables.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Wait request.
  input wire ocs_pkg::ocs_sample_t sample_in, // Output sample bundle.
  input wire logic sample_valid, // New sample this cycle.
  input wire logic overflow_evt, // Gain overflow detected this cycle.
  input wire logic sync_n, // Internal sync, active low.
  output logic int_n, // Capture interrupt pin, active low.
  output logic ovf_pin_n, // Overflow pin, active low.
  output logic pulse_pin_n, // One-shot pin, active low.
  output logic slow_tick, // Internal clock enable in power-down.
  output logic power_down, // Power-down mode active.
  output logic irq // Level interrupt from event block.
);
  logic [7:0] status;
  logic [7:0] checksum;
  logic [7:0] accum;
  ocs_pkg::ocs_sample_t held;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [3:0] events;
  logic ack;
  logic wr_hit;
  logic rd_hit;
  logic wr_status;
  logic capture;
  logic stuck;
  logic sync_d;
  logic ovf_pulse_n;
  logic [14:0] slow_cnt;
  logic [7:0] next_accum;
  logic [7:0] rd_byte;

  // The bus answers every access after exactly one wait cycle.
  // Read data is loaded at the first edge and stands at the accepting edge.
  // Writes act only at the accepting edge, so a held request never writes twice.
  // One wait cycle per access keeps read data registered and simple.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_hit = avs_write & ack & avs_byteenable[0];
  assign rd_hit = avs_read & ~ack;
  assign wr_status = wr_hit && avs_address[3:0] == ocs_pkg::IDX_STATUS && avs_address[5:4] == 2'b00;

  // A write that sets the request in the cycle of a sample loses the clear.
  assign capture = status[ocs_pkg::BIT_READY] & sample_valid & ~stuck;

  // A request write that meets a sample in the same cycle keeps the request set.
  // The stuck mark then blocks all captures until software next writes the status register.
  // Software can spot this state as missed high while the request is still high.
  // This mirrors the documented hazard rather than hiding it from software.
  // Status register: software fields, sticky flags and hardware clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= ocs_pkg::STATUS_RESET;
      stuck <= 1'b0;
    end else begin
      if (wr_status) begin
        status[ocs_pkg::BIT_READY] <= avs_writedata[ocs_pkg::BIT_READY];
        status[ocs_pkg::BIT_INT_EN] <= avs_writedata[ocs_pkg::BIT_INT_EN];
        status[ocs_pkg::BIT_SPARE] <= avs_writedata[ocs_pkg::BIT_SPARE];
        status[ocs_pkg::BIT_PULSE_SEL] <= avs_writedata[ocs_pkg::BIT_PULSE_SEL];
        status[ocs_pkg::BIT_OVF_GATE] <= avs_writedata[ocs_pkg::BIT_OVF_GATE];
        status[ocs_pkg::BIT_POWER_DOWN] <= avs_writedata[ocs_pkg::BIT_POWER_DOWN];
        stuck <= avs_writedata[ocs_pkg::BIT_READY] & sample_valid & ~status[ocs_pkg::BIT_READY];
      end else if (capture) begin
        status[ocs_pkg::BIT_READY] <= 1'b0;
      end
      if (wr_status && !avs_writedata[ocs_pkg::BIT_READY]) begin
        stuck <= 1'b0;
      end
      if (sample_valid && !status[ocs_pkg::BIT_READY]) begin
        status[ocs_pkg::BIT_MISSED] <= 1'b1;
      end else if (wr_status && !avs_writedata[ocs_pkg::BIT_MISSED]) begin
        status[ocs_pkg::BIT_MISSED] <= 1'b0;
      end
      if (overflow_evt && status[ocs_pkg::BIT_OVF_GATE]) begin
        status[ocs_pkg::BIT_OVERFLOW] <= 1'b1;
      end else if (wr_status && !avs_writedata[ocs_pkg::BIT_OVERFLOW]) begin
        status[ocs_pkg::BIT_OVERFLOW] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
    end else if (capture) begin
      held <= sample_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~status[ocs_pkg::BIT_INT_EN] | status[ocs_pkg::BIT_READY];
    end
  end

  // one-cycle overflow pulse, registered so the pin never glitches.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_pulse_n <= 1'b1;
    end else begin
      ovf_pulse_n <= ~(overflow_evt & status[ocs_pkg::BIT_OVF_GATE]);
    end
  end
  assign ovf_pin_n = status[ocs_pkg::BIT_PULSE_SEL] ? ovf_pulse_n : ~status[ocs_pkg::BIT_OVERFLOW];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_pin_n <= 1'b1;
    end else begin
      pulse_pin_n <= ~(avs_write & ack && avs_address[3:0] == ocs_pkg::IDX_ONE_SHOT
                       && avs_address[5:4] == 2'b00);
    end
  end

  // The accumulator only moves on a sample or a sync fall, so idle cycles leave it unchanged.
  // Its exact polynomial is a choice of ours; only the 8-bit width is fixed.
  // A user comparing checksums must use the same function on the reference side.
  // non-linear feedback: rotate, xor inputs, and two AND terms for non-linearity.
  always_comb begin
    next_accum = {accum[6:0], accum[7]};
    next_accum = next_accum ^ sample_in.i_word[7:0] ^ sample_in.i_word[15:8];
    next_accum = next_accum ^ sample_in.q_word[7:0] ^ sample_in.q_word[15:8];
    next_accum[0] = next_accum[0] ^ sample_in.block_strobe ^ (accum[7] & accum[3]);
    next_accum[1] = next_accum[1] ^ sample_in.frame_strobe ^ (accum[6] & accum[2]);
  end

  // latch and clear on sync falling edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      accum <= ocs_pkg::CHECKSUM_RESET;
      checksum <= ocs_pkg::CHECKSUM_RESET;
      sync_d <= 1'b1;
    end else begin
      sync_d <= sync_n;
      if (!sync_n && sync_d) begin
        checksum <= accum;
        accum <= ocs_pkg::CHECKSUM_RESET;
      end else if (sample_valid) begin
        accum <= next_accum;
      end
    end
  end

  // slow internal clock tick; the divider only runs in power-down.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt <= '0;
      slow_tick <= 1'b1;
    end else if (!status[ocs_pkg::BIT_POWER_DOWN]) begin
      slow_cnt <= '0;
      slow_tick <= 1'b1;
    end else begin
      slow_tick <= slow_cnt == 15'(ocs_pkg::SLOW_DIV - 1);
      slow_cnt <= (slow_cnt == 15'(ocs_pkg::SLOW_DIV - 1)) ? '0 : slow_cnt + 15'h0001;
    end
  end
  assign power_down = status[ocs_pkg::BIT_POWER_DOWN];

  // Each event bit stays set until software clears it through the clear register.
  // An event in the cycle of the clear is kept, so no event is ever lost.
  // The irq output is a plain level of enabled status bits.
  // Event block: sticky status, set wins over clear.
  assign events = {(!sync_n && sync_d), overflow_evt & status[ocs_pkg::BIT_OVF_GATE],
                   sample_valid & ~status[ocs_pkg::BIT_READY], capture};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= ocs_pkg::IRQ_RESET;
      irq_enable <= ocs_pkg::IRQ_RESET;
    end else begin
      if (wr_hit && avs_address == {2'b00, ocs_pkg::IDX_IRQ_ENABLE}) begin
        irq_enable <= avs_writedata[3:0];
      end
      if (wr_hit && avs_address == {2'b00, ocs_pkg::IDX_IRQ_CLEAR}) begin
        irq_status <= (irq_status & ~avs_writedata[3:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end
  assign irq = |(irq_status & irq_enable);

  // The one-shot and clear indices hold no state, so they read as zero.
  // Only the low byte carries data; the upper bytes always read zero.
  // Read mux; unmapped and write-only addresses read zero.
  always_comb begin
    rd_byte = 8'h00;
    if (avs_address[5:4] == 2'b00) begin
      unique case (avs_address[3:0])
        ocs_pkg::IDX_STATUS: rd_byte = status;
        ocs_pkg::IDX_CHECKSUM: rd_byte = checksum;
        ocs_pkg::IDX_I_LO: rd_byte = held.i_word[7:0];
        ocs_pkg::IDX_I_HI: rd_byte = held.i_word[15:8];
        ocs_pkg::IDX_Q_LO: rd_byte = held.q_word[7:0];
        ocs_pkg::IDX_Q_HI: rd_byte = held.q_word[15:8];
        ocs_pkg::IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status};
        ocs_pkg::IDX_IRQ_ENABLE: rd_byte = {4'h0, irq_enable};
        default: rd_byte = 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (rd_hit) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // Capture clears request in the cycle after the sample.
  capture_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    capture && !wr_status |=> !status[ocs_pkg::BIT_READY]) else $error("request not cleared");
  missed_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sample_valid && !status[ocs_pkg::BIT_READY] |=> status[ocs_pkg::BIT_MISSED]) else $error("missed not set");
  missed_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_status && avs_writedata[1] && status[1] |=> status[1]) else $error("missed lost on write one");
  int_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !status[ocs_pkg::BIT_INT_EN] |=> int_n) else $error("interrupt pin low while disabled");
  ovf_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !status[ocs_pkg::BIT_PULSE_SEL] |-> ovf_pin_n == !status[6]) else $error("overflow level wrong");
  ovf_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    overflow_evt && status[5] && status[4] && !$past(overflow_evt) ##1 status[4] && !overflow_evt |->
    !ovf_pin_n ##1 ovf_pin_n) else $error("overflow pulse width wrong");
  ovf_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !status[5] && !status[6] |=> !status[6]) else $error("overflow set while gated");
  oneshot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs_write && ack && avs_address == 6'h0A |=> !pulse_pin_n ##1 pulse_pin_n) else $error("one-shot pulse wrong");
  sync_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sync_n && sync_d |=> checksum == $past(accum) && accum == 8'h00) else $error("checksum not latched");
  capture_c: cover property (@(posedge ref_clk) disable iff (!rst_n) capture);
  stuck_c: cover property (@(posedge ref_clk) disable iff (!rst_n) stuck && sample_valid);
  oneshot_c: cover property (@(posedge ref_clk) disable iff (!rst_n) !pulse_pin_n);
  stuck_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) status[1] && status[0]);
  ovf_pulse_c: cover property (@(posedge ref_clk) disable iff (!rst_n) !ovf_pin_n && status[4]);

  // Cycles since the last slow tick, for the power-down check only.
  // The gap restarts on every tick, so outside power-down it stays at zero.
  // Sixteen bits hold the whole divider period with room to spare.
  // It drives no output and costs nothing once assertions are stripped.
  logic [15:0] tick_gap;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap <= '0;
    end else if (slow_tick) begin
      tick_gap <= '0;
    end else begin
      tick_gap <= tick_gap + 16'h0001;
    end
  end

  // The checks below guard the bus timing and the corner cases of each flag.
  // Each names the cycle in which the guarded value must already stand.

  // Bus: the first cycle of every request stalls.
  wait_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (avs_read || avs_write) && !ack
    |-> avs_waitrequest) else $error("no stall in first cycle");

  // Bus: the second cycle of every request is accepted.
  wait_second_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (avs_read || avs_write) && ack
    |-> !avs_waitrequest) else $error("stall in second cycle");

  // Bus: read data stands until the next read loads it.
  rdata_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rd_hit
    |=> $stable(avs_readdata)) else $error("read data moved");

  // A capture holds exactly the sample offered in its cycle.
  capture_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    capture
    |=> held == $past(sample_in)) else $error("captured sample wrong");

  // A stuck request stays high until software writes it.
  stuck_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stuck && status[ocs_pkg::BIT_READY] && !wr_status
    |=> status[ocs_pkg::BIT_READY]) else $error("stuck request cleared");

  // A stuck request takes no further samples.
  stuck_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stuck && sample_valid && !wr_status
    |=> $stable(held)) else $error("capture while stuck");

  // Writing zero clears the missed flag when no new miss arrives.
  missed_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_status && !avs_writedata[1] && !(sample_valid && !status[0])
    |=> !status[1]) else $error("missed not cleared");

  // With interrupts on, the pin follows the request bit.
  int_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    status[ocs_pkg::BIT_INT_EN]
    |=> int_n == $past(status[ocs_pkg::BIT_READY])) else $error("interrupt pin not following request");

  // A gated overflow sets the sticky flag.
  ovf_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    overflow_evt && status[5]
    |=> status[6]) else $error("overflow flag not set");

  // Writing zero clears the overflow flag when no new overflow arrives.
  ovf_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_status && !avs_writedata[6] && !(overflow_evt && status[5])
    |=> !status[6]) else $error("overflow flag not cleared");

  // Pulse mode with the gate off keeps the pin high.
  ovf_pulse_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !status[5] && !$past(status[5]) && status[4]
    |-> ovf_pin_n) else $error("overflow pin low while gated");

  // The one-shot pin stays high without a one-shot write.
  oneshot_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(avs_write && ack && avs_address == 6'h0A)
    |=> pulse_pin_n) else $error("one-shot pin low without write");

  // The checksum register only changes on a sync fall.
  checksum_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(!sync_n && sync_d)
    |=> $stable(checksum)) else $error("checksum changed without sync");

  // The accumulator moves only on a sample or a sync fall.
  accum_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sample_valid && !(!sync_n && sync_d)
    |=> $stable(accum)) else $error("accumulator moved while idle");

  // In power-down a slow tick comes at least once per divider period.
  slow_gap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    power_down
    |-> tick_gap <= 16'(ocs_pkg::SLOW_DIV)) else $error("slow tick missing");

  // Outside power-down the internal clock enable stays high.
  slow_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !power_down
    |=> slow_tick) else $error("clock enable low while running");
endmodule
